// ---- src/vds_pkg.sv ----
// Package for the vector double-shift unit: widths, latencies, states.
// Assumes one processor clock; all timing counted in clock periods.
package vds_pkg;
  localparam int VDS_ELEM_W = 64;
  localparam int VDS_PAIR_W = 128;
  localparam int VDS_NUM_ELEM = 64;
  localparam int VDS_VL_W = 7;
  localparam int VDS_IDX_W = 6;
  localparam int VDS_CNT_W = 24;
  localparam int VDS_DESIG_W = 3;
  localparam logic [2:0] VDS_DESIG_ZERO = 3'h0;
  localparam logic [23:0] VDS_DEFAULT_COUNT = 24'h000001;
  localparam logic [23:0] VDS_COUNT_CLEAR = 24'h000080;
  // Result-ready and busy latencies beyond vector length, in clock periods
  localparam int VDS_LEFT_READY_CP = 9;
  localparam int VDS_RIGHT_READY_CP = 8;
  localparam int VDS_UNIT_BUSY_CP = 4;
  localparam real VDS_CLK_MHZ = 25.0;
  // Latencies are specified in clock periods directly: one cycle per period
  localparam int VDS_LEFT_READY_CYC = VDS_LEFT_READY_CP;
  localparam int VDS_RIGHT_READY_CYC = VDS_RIGHT_READY_CP;
  localparam int VDS_BUSY_CYC = VDS_UNIT_BUSY_CP;
  typedef enum logic [2:0] {
    VDS_IDLE = 3'h1,
    VDS_RUN = 3'h2,
    VDS_DRAIN = 3'h4
  } vds_state_t;
endpackage : vds_pkg

// ---- src/vds_shift_core.sv ----
// Combinational 128-bit pair shifter for one element.
// Assumes count is unsigned and already resolved for designator zero.
`timescale 1ns/10ps
`default_nettype none
module vds_shift_core
  import vds_pkg::*;
(
  input wire logic dir_right,
  input wire logic [VDS_ELEM_W-1:0] hi_word,
  input wire logic [VDS_ELEM_W-1:0] lo_word,
  input wire logic [VDS_CNT_W-1:0] count,
  output logic [VDS_ELEM_W-1:0] result
);
  logic [VDS_PAIR_W-1:0] pair;
  logic [VDS_PAIR_W-1:0] shifted;

  // End-off shift with zero fill; huge counts clear all
  always_comb begin
    pair = {hi_word, lo_word};
    if (count >= VDS_COUNT_CLEAR) begin
      shifted = '0;
    end else if (dir_right) begin
      shifted = pair >> count[6:0];
    end else begin
      shifted = pair << count[6:0];
    end
    result = dir_right ? shifted[VDS_ELEM_W-1:0] : shifted[VDS_PAIR_W-1:VDS_ELEM_W];
  end
endmodule : vds_shift_core
`default_nettype wire

// ---- src/vds_unit.sv ----
// Vector double-shift unit: element stream in, shifted element stream out.
// Assumes issue logic holds instructions while busy or operands reserved;
// the source vector arrives in order, one element per valid strobe.
`timescale 1ns/10ps
`default_nettype none
module vds_unit
  import vds_pkg::*;
#(
  parameter int ELEM_W = VDS_ELEM_W
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic dir_right,
  input wire logic [VDS_VL_W-1:0] vector_length_reg,
  input wire logic [VDS_DESIG_W-1:0] count_desig,
  input wire logic [VDS_CNT_W-1:0] shift_count_reg,
  input wire logic src_valid,
  input wire logic [ELEM_W-1:0] source_vector,
  output logic res_we,
  output logic [VDS_IDX_W-1:0] res_idx,
  output logic [ELEM_W-1:0] result_vector,
  output logic unit_busy,
  output logic result_ready
);
  vds_state_t state_ff;
  vds_state_t nxt_state;
  logic dir_ff;
  logic [VDS_VL_W-1:0] len_ff;
  logic [VDS_CNT_W-1:0] cnt_ff;
  logic [VDS_VL_W-1:0] in_cnt_ff;
  logic [ELEM_W-1:0] prev_ff;
  logic [VDS_VL_W+3:0] lat_ff;
  logic [VDS_VL_W+3:0] lat_goal_ff;
  logic [ELEM_W-1:0] sh_hi;
  logic [ELEM_W-1:0] sh_lo;
  logic [ELEM_W-1:0] sh_res;
  logic take;
  logic flush;
  logic last_in;

  // Operand accepted only when present
  assign take = (state_ff == VDS_RUN) && src_valid;
  assign last_in = (in_cnt_ff + 7'h01) == len_ff;
  // Left shift flushes last element against zeros after all arrive
  assign flush = (state_ff == VDS_DRAIN) && !dir_ff;

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      VDS_IDLE: begin
        if (start && vector_length_reg != 7'h00) begin
          nxt_state = VDS_RUN;
        end
      end
      VDS_RUN: begin
        if (take && last_in) begin
          nxt_state = VDS_DRAIN;
        end
      end
      VDS_DRAIN: begin
        nxt_state = VDS_IDLE;
      end
      default: begin
        nxt_state = VDS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= VDS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Lengths above the register file size are cut to a full vector
  function automatic logic [VDS_VL_W-1:0] clamp_len(input logic [VDS_VL_W-1:0] vl);
    return (vl > VDS_VL_W'(VDS_NUM_ELEM)) ? VDS_VL_W'(VDS_NUM_ELEM) : vl;
  endfunction : clamp_len

  // Latch instruction fields at start
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dir_ff <= 1'b0;
      len_ff <= 7'h00;
      cnt_ff <= 24'h000000;
    end else if (state_ff == VDS_IDLE && start) begin
      dir_ff <= dir_right;
      len_ff <= clamp_len(vector_length_reg);
      cnt_ff <= (count_desig == VDS_DESIG_ZERO) ? VDS_DEFAULT_COUNT
                : shift_count_reg;
    end
  end

  // Input element counter and previous element hold
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      in_cnt_ff <= 7'h00;
      prev_ff <= '0;
    end else if (state_ff == VDS_IDLE) begin
      in_cnt_ff <= 7'h00;
      prev_ff <= '0;
    end else if (take) begin
      in_cnt_ff <= in_cnt_ff + 7'h01;
      prev_ff <= source_vector;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pair selection
  always_comb begin
    if (dir_ff) begin
      sh_hi = prev_ff;
      sh_lo = source_vector;
    end else if (flush) begin
      sh_hi = prev_ff;
      sh_lo = '0;
    end else begin
      sh_hi = prev_ff;
      sh_lo = source_vector;
    end
  end

  vds_shift_core u_core (
    .dir_right(dir_ff),
    .hi_word(sh_hi),
    .lo_word(sh_lo),
    .count(cnt_ff),
    .result(sh_res)
  );

  // Result writes; left shift writes element n when n+1 arrives
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      res_we <= 1'b0;
      res_idx <= 6'h00;
      result_vector <= '0;
    end else begin
      res_we <= 1'b0;
      if (take && (dir_ff || in_cnt_ff != 7'h00)) begin
        res_we <= 1'b1;
        res_idx <= dir_ff ? in_cnt_ff[5:0] : 6'(in_cnt_ff - 7'h01);
        result_vector <= sh_res;
      end else if (flush) begin
        res_we <= 1'b1;
        res_idx <= 6'(len_ff - 7'h01);
        result_vector <= sh_res;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Busy and result-ready timers: start at first data, pause on gaps while running
  // Counting on after the last element keeps them alive once the input counter clears
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lat_ff <= '0;
      lat_goal_ff <= '0;
      result_ready <= 1'b0;
    end else if (state_ff == VDS_IDLE && start && vector_length_reg != 7'h00) begin
      lat_ff <= '0;
      result_ready <= 1'b0;
      lat_goal_ff <= 11'(clamp_len(vector_length_reg)) + (dir_right ? 11'(VDS_RIGHT_READY_CYC)
                     : 11'(VDS_LEFT_READY_CYC));
    end else if (!result_ready && (take || (state_ff != VDS_RUN && lat_ff != '0))) begin
      lat_ff <= lat_ff + 11'h001;
      if (lat_ff >= lat_goal_ff) begin
        result_ready <= 1'b1;
      end
    end
  end

  // Unit busy while shifting plus fixed tail
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      unit_busy <= 1'b0;
    end else if (state_ff == VDS_IDLE && start && vector_length_reg != 7'h00) begin
      unit_busy <= 1'b1;
    end else if (state_ff == VDS_IDLE && unit_busy
                 && lat_ff >= 11'(len_ff) + 11'(VDS_BUSY_CYC)) begin
      unit_busy <= 1'b0;
    end else if (state_ff == VDS_IDLE && unit_busy && result_ready) begin
      unit_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_clear_big: assert property (@(posedge clk_sys) disable iff (!nrst)
    (res_we && $past(cnt_ff) >= VDS_COUNT_CLEAR) |-> result_vector == '0)
    else $error("nonzero result with count of 128 or more");
  chk_idx_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    res_we |-> 7'(res_idx) < len_ff)
    else $error("write beyond vector length");
  chk_need_data: assert property (@(posedge clk_sys) disable iff (!nrst)
    (res_we && $past(dir_ff)) |-> $past(src_valid))
    else $error("right result without operand");
  chk_zero_fill: assert property (@(posedge clk_sys) disable iff (!nrst)
    (res_we && $past(cnt_ff) > 24'h40 && $past(cnt_ff) < VDS_COUNT_CLEAR && $past(dir_ff))
    |-> (result_vector >> (8'h80 - 8'($past(cnt_ff)))) == '0)
    else $error("too few zero bits");
  chk_zero_left: assert property (@(posedge clk_sys) disable iff (!nrst)
    (res_we && $past(cnt_ff) > 24'h40 && $past(cnt_ff) < VDS_COUNT_CLEAR && !$past(dir_ff))
    |-> (result_vector << (8'h80 - 8'($past(cnt_ff)))) == '0)
    else $error("too few zero bits on left shift");
  chk_one_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_ff == VDS_DRAIN && len_ff == 7'h01 && dir_ff) |-> res_idx == 6'h00)
    else $error("length one wrote other element");
  chk_desig_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_ff == VDS_IDLE && start && count_desig == VDS_DESIG_ZERO) |=> cnt_ff == 24'h1)
    else $error("designator zero count not one");
  chk_right_first: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && dir_ff && in_cnt_ff == 7'h00) |-> prev_ff == '0)
    else $error("right first pair not zero-extended");
  chk_ready_late: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(result_ready) |-> lat_ff >= lat_goal_ff)
    else $error("result ready too early");
  cov_left: cover property (@(posedge clk_sys) disable iff (!nrst) flush);
  cov_right: cover property (@(posedge clk_sys) disable iff (!nrst) take && dir_ff);
  cov_big: cover property (@(posedge clk_sys) disable iff (!nrst)
    res_we && cnt_ff >= VDS_COUNT_CLEAR);
endmodule : vds_unit
`default_nettype wire

// ---- tb/vds_issue_model.sv ----
// Issue-side model: holds issue until the unit is idle, then issues and streams.
// Assumes one clock; drives its outputs 1 ns after the rising edge.
`timescale 1ns/10ps
`default_nettype none
module vds_issue_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic slow,
  input wire logic [6:0] len,
  input wire logic [63:0] base,
  input wire logic unit_busy,
  output logic start,
  output logic src_valid,
  output logic [63:0] source_vector
);
  ////////////////////////////////////////////////////////////////////////////
  // Issue one instruction per request, then send elements in order
  initial begin
    start = 1'b0;
    src_valid = 1'b0;
    source_vector = 64'h0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        while (unit_busy) @(posedge clk_sys);
        #1 start = 1'b1;
        @(posedge clk_sys);
        #1 start = 1'b0;
        for (int i = 0; i < len; i++) begin
          // Stalled upstream load: gaps between elements
          if (slow) begin
            src_valid = 1'b0;
            source_vector = ~source_vector;
            repeat (2) @(posedge clk_sys);
            #1;
          end
          src_valid = 1'b1;
          source_vector = base ^ {i[7:0], 48'h0, i[7:0]};
          @(posedge clk_sys);
          #1;
        end
        // Released data never shows the last element
        src_valid = 1'b0;
        source_vector = ~source_vector;
      end
    end
  end
endmodule : vds_issue_model
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench for the double-shift unit: the issue model streams, tasks judge.
// Assumes a 25 MHz clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vds_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic dir_right = 1'b0;
  logic [6:0] vector_length_reg = 7'h00;
  logic [2:0] count_desig = 3'h0;
  logic [23:0] shift_count_reg = 24'h000000;
  logic [63:0] base = 64'hF0E1D2C3B4A59687;
  logic start, src_valid, res_we, unit_busy, result_ready;
  logic [63:0] source_vector, result_vector;
  logic [5:0] res_idx;
  int num_errors = 0;
  int comparisons = 0;

  always #20 clk_sys = ~clk_sys;

  vds_issue_model model_u (.clk_sys, .go, .slow, .len(vector_length_reg), .base,
    .unit_busy, .start, .src_valid, .source_vector);
  vds_unit dut_u (.clk_sys, .nrst, .start, .dir_right, .vector_length_reg, .count_desig,
    .shift_count_reg, .src_valid, .source_vector, .res_we, .res_idx, .result_vector,
    .unit_busy, .result_ready);

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  function automatic logic [63:0] elem(input int i);
    return base ^ {i[7:0], 48'h0, i[7:0]};
  endfunction : elem

  // One instruction: expected results, issue, then judge every write
  task automatic run_op(input logic dr, input logic [6:0] n, input logic [2:0] ds,
      input logic [23:0] cnt, input logic sl);
    logic [63:0] ev [64];
    logic [127:0] sh;
    logic [23:0] c;
    int t0;
    int t1;
    int t2;
    int nw;
    logic seen_busy;
    t0 = -1;
    t1 = -1;
    t2 = -1;
    nw = 0;
    seen_busy = 1'b0;
    c = (ds == 3'h0) ? 24'h000001 : cnt;
    for (int i = 0; i < n; i++) begin
      if (dr) sh = {(i == 0) ? 64'h0 : elem(i - 1), elem(i)} >> c;
      else sh = {elem(i), (i == n - 1) ? 64'h0 : elem(i + 1)} << c;
      ev[i] = dr ? sh[63:0] : sh[127:64];
    end
    @(posedge clk_sys);
    #1;
    dir_right = dr;
    vector_length_reg = n;
    count_desig = ds;
    shift_count_reg = cnt;
    slow = sl;
    go = 1'b1;
    for (int k = 0; k < 400; k++) begin
      @(posedge clk_sys);
      #1;
      go = 1'b0;
      if (src_valid === 1'b1 && t0 < 0) t0 = k + 1;
      if (unit_busy === 1'b1) seen_busy = 1'b1;
      if (seen_busy && unit_busy === 1'b0 && t2 < 0) t2 = k;
      if (res_we === 1'b1) begin
        check(64'(res_idx < n), 64'h1);
        check(result_vector, ev[res_idx]);
        nw++;
      end
      if (seen_busy && result_ready === 1'b1 && t1 < 0) t1 = k;
      if (t1 >= 0 && unit_busy === 1'b0) break;
    end
    check(64'(nw), 64'(n));
    check(64'(seen_busy), 64'(n != 7'h00));
    if (!sl && n != 7'h00) begin
      check(64'(t1 - t0), 64'(n + (dr ? VDS_RIGHT_READY_CYC : VDS_LEFT_READY_CYC)));
      check(64'(t2 - t0), 64'(n + VDS_BUSY_CYC));
    end
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_right_chain;
    run_op(1'b1, 7'h04, 3'h6, 24'h000003, 1'b0);
  endtask : t_right_chain

  task automatic t_left_chain;
    run_op(1'b0, 7'h04, 3'h6, 24'h000003, 1'b0);
  endtask : t_left_chain

  task automatic t_single;
    run_op(1'b1, 7'h01, 3'h2, 24'h000005, 1'b0);
    run_op(1'b0, 7'h01, 3'h2, 24'h000046, 1'b0);
    run_op(1'b1, 7'h00, 3'h2, 24'h000005, 1'b0);
  endtask : t_single

  task automatic t_desig_zero;
    run_op(1'b1, 7'h03, 3'h0, 24'hFFFFFF, 1'b0);
    run_op(1'b0, 7'h03, 3'h0, 24'h000040, 1'b0);
  endtask : t_desig_zero

  task automatic t_big_counts;
    run_op(1'b0, 7'h02, 3'h5, 24'h000080, 1'b0);
    run_op(1'b1, 7'h02, 3'h5, 24'hFFFFFF, 1'b0);
    run_op(1'b1, 7'h03, 3'h5, 24'h00007F, 1'b0);
  endtask : t_big_counts

  task automatic t_full_length;
    run_op(1'b0, 7'h40, 3'h1, 24'h000021, 1'b1);
    run_op(1'b1, 7'h40, 3'h1, 24'h00003F, 1'b0);
  endtask : t_full_length

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    #1 nrst = 1'b1;
    t_right_chain();
    t_left_chain();
    t_single();
    t_desig_zero();
    t_big_counts();
    t_full_length();
    give_verdict();
  end

  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
